//--- design/lbb_led_bank.sv
// LED driver configuration and bank A brightness register bank
`timescale 1ns/1ns
`include "lbb_map.svh"
// Function
// R1: Device ramps low brightness bits between high-byte levels, giving 11-bit dimming.
// R2: Low byte write waits pending; applied only when high byte is written.
// R3: In 11-bit PWM mode host writes low then high byte per change.
// R4: In 8-bit mode host writes low byte zero once, then only high.
// R5: Sink assignment 0x04 puts sinks one and two on bank A.
// R6: Feedback register 0x03 enables sinks one, two; disables sink three.
// R7: Boost 0x04 gives 32 V, 0x02 gives 24 V, both 500 kHz.
// R8: PWM config 0x0D: zero detect, active high, bank B off, A on.
// R9: Bank enable 0x01 enables control bank A.
// R10: Reset defaults: 2048 us ramp, exponential mapping, 20.2 mA full scale.
// R11: Overvoltage limit returns to 16 V after any reset, hardware enable included.
// R12: All registers are 8-bit read-write and hold values until reset.
module lbb_led_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hardware_enable_pin,
  // Two-wire register port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Sink routing
  output logic [2:0] sink_bank_b,
  output logic [2:0] sink_feedback_en,
  // Boost
  output logic [1:0] overvoltage_limit,
  output logic switching_frequency,
  // PWM input setup
  output logic pwm_bank_a_en,
  output logic pwm_bank_b_en,
  output logic pwm_active_high,
  output logic pwm_zero_detect,
  // Banks and brightness
  output logic bank_a_enable,
  output logic bank_b_enable,
  output lbb_pkg::lbb_level_t bank_a_target,
  output lbb_pkg::lbb_level_t bank_a_level,
  // Fixed defaults
  output logic [11:0] ramp_time_us,
  output logic map_exponential,
  output logic [15:0] full_scale_ua
);
  lbb_pkg::lbb_byte_t reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, tick, clr;
  lbb_pkg::lbb_byte_t sink_q, sink_d, fb_q, fb_d, boost_q, boost_d, pwm_q, pwm_d;
  lbb_pkg::lbb_byte_t low_q, low_d, high_q, high_d, en_q, en_d;
  logic [2:0] low_app_q, low_app_d;
  lbb_pkg::lbb_level_t level_q, level_d;
  logic [11:0] tick_q, tick_d;

  // Level moves one count per tick so every change is a smooth ramp, except the jump to zero while hardware enable is low
  function automatic lbb_pkg::lbb_level_t step_toward(lbb_pkg::lbb_level_t cur,
                                                      lbb_pkg::lbb_level_t tgt);
    if (cur < tgt) begin
      step_toward = cur + 11'h001;
    end else if (cur > tgt) begin
      step_toward = cur - 11'h001;
    end else begin
      step_toward = cur;
    end
  endfunction : step_toward

  lbb_serial_port u_port (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  // Hardware enable low acts as a reset of the whole bank
  assign clr = !hardware_enable_pin;

  always_comb begin
    sink_d = sink_q;
    fb_d = fb_q;
    boost_d = boost_q;
    pwm_d = pwm_q;
    low_d = low_q;
    high_d = high_q;
    en_d = en_q;
    low_app_d = low_app_q;
    if (clr) begin
      // R11 16 V restore
      sink_d = `LBB_RST_BYTE;
      fb_d = `LBB_RST_BYTE;
      boost_d = `LBB_RST_BYTE;
      pwm_d = `LBB_RST_BYTE;
      low_d = `LBB_RST_BYTE;
      high_d = `LBB_RST_BYTE;
      en_d = `LBB_RST_BYTE;
      low_app_d = 3'h0;
    end else if (reg_wr) begin
      // R12 byte-wide storage
      if (reg_addr == `LBB_ADDR_SINK) begin
        sink_d = reg_wdata;
      end else if (reg_addr == `LBB_ADDR_FB) begin
        fb_d = reg_wdata;
      end else if (reg_addr == `LBB_ADDR_BOOST) begin
        boost_d = reg_wdata;
      end else if (reg_addr == `LBB_ADDR_PWM) begin
        pwm_d = reg_wdata;
      end else if (reg_addr == `LBB_ADDR_LOW) begin
        // R2 hold low pending
        low_d = reg_wdata;
      end else if (reg_addr == `LBB_ADDR_HIGH) begin
        high_d = reg_wdata;
        // R2 apply on high write
        low_app_d = low_q[`LBB_LOW_FIELD];
      end else if (reg_addr == `LBB_ADDR_EN) begin
        en_d = reg_wdata;
      end
    end
  end

  // Reads return stored bytes; the pending low byte reads back as written
  always_comb begin
    if (reg_addr == `LBB_ADDR_SINK) begin
      reg_rdata = sink_q;
    end else if (reg_addr == `LBB_ADDR_FB) begin
      reg_rdata = fb_q;
    end else if (reg_addr == `LBB_ADDR_BOOST) begin
      reg_rdata = boost_q;
    end else if (reg_addr == `LBB_ADDR_PWM) begin
      reg_rdata = pwm_q;
    end else if (reg_addr == `LBB_ADDR_LOW) begin
      reg_rdata = low_q;
    end else if (reg_addr == `LBB_ADDR_HIGH) begin
      reg_rdata = high_q;
    end else if (reg_addr == `LBB_ADDR_EN) begin
      reg_rdata = en_q;
    end else begin
      reg_rdata = `LBB_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brightness ramp
  // R1 target from high byte and applied low bits
  assign bank_a_target = {high_q, low_app_q};
  assign tick = (tick_q == 12'(`LBB_STEP_CYC - 1));

  always_comb begin
    tick_d = tick ? 12'h000 : tick_q + 12'h001;
    level_d = level_q;
    if (clr) begin
      tick_d = 12'h000;
      level_d = `LBB_RST_LEVEL;
    end else if (tick) begin
      // R1 step the low bits
      level_d = step_toward(level_q, bank_a_target);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sink_q <= `LBB_RST_BYTE;
      fb_q <= `LBB_RST_BYTE;
      boost_q <= `LBB_RST_BYTE;
      pwm_q <= `LBB_RST_BYTE;
      low_q <= `LBB_RST_BYTE;
      high_q <= `LBB_RST_BYTE;
      en_q <= `LBB_RST_BYTE;
      low_app_q <= 3'h0;
      level_q <= `LBB_RST_LEVEL;
      tick_q <= 12'h000;
    end else begin
      sink_q <= sink_d;
      fb_q <= fb_d;
      boost_q <= boost_d;
      pwm_q <= pwm_d;
      low_q <= low_d;
      high_q <= high_d;
      en_q <= en_d;
      low_app_q <= low_app_d;
      level_q <= level_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // R5 sink routing
  assign sink_bank_b = sink_q[`LBB_SINK_FIELD];
  // R6 feedback enables
  assign sink_feedback_en = fb_q[`LBB_FB_FIELD];
  // R7 limit and frequency
  assign overvoltage_limit = boost_q[`LBB_BOOST_LIMIT];
  assign switching_frequency = boost_q[`LBB_BOOST_FREQ];
  // R8 PWM fields
  assign pwm_bank_a_en = pwm_q[`LBB_PWM_A];
  assign pwm_bank_b_en = pwm_q[`LBB_PWM_B];
  assign pwm_active_high = pwm_q[`LBB_PWM_POL];
  assign pwm_zero_detect = pwm_q[`LBB_PWM_ZDET];
  // R9 bank enables
  assign bank_a_enable = en_q[`LBB_EN_A];
  assign bank_b_enable = en_q[`LBB_EN_B];
  assign bank_a_level = level_q;
  // R10 fixed defaults; no register reaches them
  assign ramp_time_us = `LBB_RST_RAMP_US;
  assign map_exponential = `LBB_RST_MAP_EXP;
  assign full_scale_ua = `LBB_RST_FS_UA;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_low_wr;
    reg_wr && reg_addr == `LBB_ADDR_LOW;
  endsequence
  sequence s_high_wr;
    reg_wr && reg_addr == `LBB_ADDR_HIGH;
  endsequence

  a_low_held_pending: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R2
    s_low_wr |=> low_app_q == $past(low_app_q))
    else $error("low byte applied without high write");
  a_low_applied_high: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R2
    s_low_wr ##[1:300] s_high_wr |=> low_app_q == $past(low_q[`LBB_LOW_FIELD]))
    else $error("pending low bits not applied on high write");
  a_level_one_step: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R1
    level_q != $past(level_q) |-> $past(tick) &&
      (level_q == $past(level_q) + 11'h001 || level_q == $past(level_q) - 11'h001))
    else $error("level moved off tick or by more than one");
  a_target_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    s_high_wr ##1 hardware_enable_pin |-> bank_a_target[10:3] == $past(reg_wdata))
    else $error("target does not follow high byte");
  a_sink_map: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    reg_wr && reg_addr == `LBB_ADDR_SINK && reg_wdata == 8'h04 ##1 hardware_enable_pin
      |-> sink_bank_b == 3'h4)
    else $error("sinks one and two not on bank A");
  a_feedback_map: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    reg_wr && reg_addr == `LBB_ADDR_FB && reg_wdata == 8'h03 ##1 hardware_enable_pin
      |-> sink_feedback_en == 3'h3)
    else $error("feedback enables wrong");
  a_boost_32v: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    reg_wr && reg_addr == `LBB_ADDR_BOOST && reg_wdata == 8'h04 ##1 hardware_enable_pin
      |-> overvoltage_limit == `LBB_LIMIT_32V && !switching_frequency)
    else $error("boost setting 32 V wrong");
  a_pwm_setup: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    reg_wr && reg_addr == `LBB_ADDR_PWM && reg_wdata == 8'h0D ##1 hardware_enable_pin
      |-> pwm_zero_detect && pwm_active_high && !pwm_bank_b_en && pwm_bank_a_en)
    else $error("PWM setup fields wrong");
  a_bank_a_on: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    reg_wr && reg_addr == `LBB_ADDR_EN && reg_wdata == 8'h01 ##1 hardware_enable_pin
      |-> bank_a_enable && !bank_b_enable)
    else $error("bank A not enabled");
  a_defaults_fixed: assert property (@(posedge clk_sys) // R10
    ramp_time_us == 12'h800 && map_exponential && full_scale_ua == 16'h4EE8)
    else $error("default ramp, mapping or current wrong");
  a_limit_reset: assert property (@(posedge clk_sys) // R11
    !rst_n || clr |=> overvoltage_limit == `LBB_LIMIT_16V)
    else $error("limit not 16 V after reset");
  a_reg_readback: assert property (@(posedge clk_sys) disable iff (!rst_n || clr) // R12
    reg_wr ##1 !reg_wr && reg_addr == $past(reg_addr) && reg_addr >= `LBB_ADDR_SINK
      && (reg_addr == `LBB_ADDR_EN || reg_addr == `LBB_ADDR_BOOST)
      |-> reg_rdata == $past(reg_wdata))
    else $error("register did not hold written value");
endmodule : lbb_led_bank

//--- design/lbb_map.svh
// Register offsets, reset values, field positions and timing of the LED bank
`ifndef LBB_MAP_SVH
`define LBB_MAP_SVH

// Register offsets
`define LBB_ADDR_SINK 8'h10
`define LBB_ADDR_FB 8'h19
`define LBB_ADDR_BOOST 8'h1A
`define LBB_ADDR_PWM 8'h1C
`define LBB_ADDR_LOW 8'h20
`define LBB_ADDR_HIGH 8'h21
`define LBB_ADDR_EN 8'h24

// Port address, value arbitrary
`define LBB_DEV_ADDR 7'h36

// Reset values
`define LBB_RST_BYTE 8'h00
`define LBB_RST_LEVEL 11'h000
`define LBB_RST_RAMP_US 12'h800
`define LBB_RST_MAP_EXP 1'b1
`define LBB_RST_FS_UA 16'h4EE8

// Fields
`define LBB_SINK_FIELD 2:0
`define LBB_FB_FIELD 2:0
`define LBB_LOW_FIELD 2:0
`define LBB_BOOST_FREQ 0
`define LBB_BOOST_LIMIT 2:1
`define LBB_LIMIT_16V 2'h0
`define LBB_LIMIT_24V 2'h1
`define LBB_LIMIT_32V 2'h2
`define LBB_PWM_A 0
`define LBB_PWM_B 1
`define LBB_PWM_POL 2
`define LBB_PWM_ZDET 3
`define LBB_EN_A 0
`define LBB_EN_B 1

// Timing: one ramp time per high-byte level, split into eight low steps
`define LBB_RAMP_TIME_US 2048
`define LBB_CLK_MHZ 10
`define LBB_RAMP_STEPS 8
`define LBB_STEP_CYC ((`LBB_RAMP_TIME_US * `LBB_CLK_MHZ) / `LBB_RAMP_STEPS)

`endif

//--- design/lbb_pkg.sv
// Types shared by the LED bank design
package lbb_pkg;
  typedef logic [7:0] lbb_byte_t;
  typedef logic [10:0] lbb_level_t;
  typedef enum logic [2:0] {
    LBB_IDLE, LBB_ADDR, LBB_ACK_ADDR, LBB_RECV, LBB_ACK_RECV, LBB_SEND, LBB_ACK_SEND
  } lbb_port_state_t;
endpackage : lbb_pkg

//--- design/lbb_serial_port.sv
// Serial register port: two-wire slave with register pointer
`timescale 1ns/1ns
`include "lbb_map.svh"
module lbb_serial_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Two-wire pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register side
  output lbb_pkg::lbb_byte_t reg_addr,
  output lbb_pkg::lbb_byte_t reg_wdata,
  output logic reg_wr,
  input wire lbb_pkg::lbb_byte_t reg_rdata
);
  lbb_pkg::lbb_port_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wd_q, wd_d;
  logic scl_q, sda_q, oe_q, oe_d, rd_q, rd_d, wr_q, wr_d, first_q, first_d;
  logic rise, fall, start, stop;

  assign rise = scl && !scl_q;
  assign fall = !scl && scl_q;
  assign start = scl && scl_q && sda_q && !sda_in;
  assign stop = scl && scl_q && !sda_q && sda_in;
  // Open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign reg_addr = ptr_q;
  assign reg_wdata = wd_q;
  assign reg_wr = wr_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    wd_d = wd_q;
    oe_d = oe_q;
    rd_d = rd_q;
    wr_d = 1'b0;
    first_d = first_q;
    if (start) begin
      st_d = lbb_pkg::LBB_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = lbb_pkg::LBB_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        lbb_pkg::LBB_ADDR, lbb_pkg::LBB_RECV: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            if (st_q == lbb_pkg::LBB_ADDR) begin
              // Foreign address: stay off the bus until the next start
              if (sh_q[7:1] == `LBB_DEV_ADDR) begin
                oe_d = 1'b1;
                rd_d = sh_q[0];
                st_d = lbb_pkg::LBB_ACK_ADDR;
              end else begin
                st_d = lbb_pkg::LBB_IDLE;
              end
            end else begin
              oe_d = 1'b1;
              st_d = lbb_pkg::LBB_ACK_RECV;
              if (first_q) begin
                ptr_d = sh_q;
              end else begin
                wd_d = sh_q;
                wr_d = 1'b1;
              end
            end
          end
        end
        lbb_pkg::LBB_ACK_ADDR: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rd_q) begin
              sh_d = reg_rdata;
              oe_d = !reg_rdata[7];
              st_d = lbb_pkg::LBB_SEND;
            end else begin
              oe_d = 1'b0;
              first_d = 1'b1;
              st_d = lbb_pkg::LBB_RECV;
            end
          end
        end
        lbb_pkg::LBB_ACK_RECV: begin
          if (fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            st_d = lbb_pkg::LBB_RECV;
            if (!first_q) begin
              ptr_d = ptr_q + 8'h01;
            end
            first_d = 1'b0;
          end
        end
        lbb_pkg::LBB_SEND: begin
          if (rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (fall) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = lbb_pkg::LBB_ACK_SEND;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = !sh_q[6];
            end
          end
        end
        lbb_pkg::LBB_ACK_SEND: begin
          if (rise) begin
            // Master not-acknowledge ends the read burst
            if (sda_in) begin
              st_d = lbb_pkg::LBB_IDLE;
            end else begin
              ptr_d = ptr_q + 8'h01;
            end
          end else if (fall) begin
            sh_d = reg_rdata;
            oe_d = !reg_rdata[7];
            cnt_d = 4'h0;
            st_d = lbb_pkg::LBB_SEND;
          end
        end
        default: begin
          st_d = lbb_pkg::LBB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= lbb_pkg::LBB_IDLE;
      cnt_q <= 4'h0;
      sh_q <= `LBB_RST_BYTE;
      ptr_q <= `LBB_RST_BYTE;
      wd_q <= `LBB_RST_BYTE;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      first_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      wd_q <= wd_d;
      oe_q <= oe_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      first_q <= first_d;
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end
endmodule : lbb_serial_port

//--- testbench/lbb_host_model.sv
// Host controller model driving the two-wire register port
`timescale 1ns/1ns
`include "lbb_map.svh"
module lbb_host_model (
  // Clock
  input wire logic clk_sys,
  // Two-wire pins, data released means pulled high
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  // Clock low and high phase unit, raised by the bench for a slow host
  int half = 2;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic step(input logic c, input logic d, input int n);
    @(posedge clk_sys);
    scl <= c;
    sda_rel <= d;
    repeat (n - 1) @(posedge clk_sys);
  endtask : step
  // Data moves only while the clock is low, never on its edges
  task automatic bit_io(input logic b, output logic s);
    step(1'b0, sda_rel, half);
    step(1'b0, b, half);
    step(1'b1, b, half);
    s = sda_line;
    step(1'b1, b, half);
  endtask : bit_io
  task automatic bus_start();
    step(1'b0, sda_rel, half);
    step(1'b0, 1'b1, half);
    step(1'b1, 1'b1, 2 * half);
    step(1'b1, 1'b0, 2 * half);
  endtask : bus_start
  task automatic bus_stop();
    step(1'b0, sda_rel, half);
    step(1'b0, 1'b0, half);
    step(1'b1, 1'b0, 2 * half);
    step(1'b1, 1'b1, 2 * half);
  endtask : bus_stop
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, s);
  endtask : get_byte
  ////////////////////////////////////////////////////////////
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [2:0] k;
    bus_start();
    put_byte({`LBB_DEV_ADDR, 1'b0}, k[0]);
    put_byte(a, k[1]);
    put_byte(d, k[2]);
    bus_stop();
    ok = &k;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [2:0] k;
    bus_start();
    put_byte({`LBB_DEV_ADDR, 1'b0}, k[0]);
    put_byte(a, k[1]);
    bus_start();
    put_byte({`LBB_DEV_ADDR, 1'b1}, k[2]);
    get_byte(1'b0, d);
    bus_stop();
    ok = &k;
  endtask : read_reg
  task automatic write_level(input logic [7:0] lo, input logic [7:0] hi, output logic ok);
    logic [1:0] k;
    write_reg(`LBB_ADDR_LOW, lo, k[0]);
    write_reg(`LBB_ADDR_HIGH, hi, k[1]);
    ok = &k;
  endtask : write_level
endmodule : lbb_host_model

//--- testbench/tb_top.sv
// Self-checking bench of the LED bank register block
`timescale 1ns/1ns
`include "lbb_map.svh"
module tb_top;
  localparam int LIMIT = 85000;
  logic clk_sys;
  logic rst_n;
  logic hardware_enable_pin;
  logic scl;
  logic sda_rel;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  logic [2:0] sink_bank_b;
  logic [2:0] sink_feedback_en;
  logic [1:0] overvoltage_limit;
  logic switching_frequency;
  logic pwm_bank_a_en;
  logic pwm_bank_b_en;
  logic pwm_active_high;
  logic pwm_zero_detect;
  logic bank_a_enable;
  logic bank_b_enable;
  lbb_pkg::lbb_level_t bank_a_target;
  lbb_pkg::lbb_level_t bank_a_level;
  lbb_pkg::lbb_level_t lvl_prev;
  logic [11:0] ramp_time_us;
  logic map_exponential;
  logic [15:0] full_scale_ua;
  logic ok;
  logic seen;
  logic [7:0] rd;
  int gap;
  int fails;
  int total_checks;
  int cycles;
  logic [7:0] regs [7] = '{`LBB_ADDR_SINK, `LBB_ADDR_FB, `LBB_ADDR_BOOST, `LBB_ADDR_PWM,
    `LBB_ADDR_EN, `LBB_ADDR_LOW, `LBB_ADDR_HIGH};
  // Pull-up on the data line
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);
  lbb_led_bank u_lbb_led_bank (.clk_sys, .rst_n, .hardware_enable_pin, .scl, .sda_in(sda_line),
    .sda_out, .sda_oe, .sink_bank_b, .sink_feedback_en, .overvoltage_limit,
    .switching_frequency, .pwm_bank_a_en, .pwm_bank_b_en, .pwm_active_high, .pwm_zero_detect,
    .bank_a_enable, .bank_b_enable, .bank_a_target, .bank_a_level, .ramp_time_us,
    .map_exponential, .full_scale_ua);
  lbb_host_model u_lbb_host_model (.clk_sys, .scl, .sda_rel, .sda_line);
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      `LBB_ADDR_SINK, `LBB_ADDR_FB, `LBB_ADDR_BOOST: return 8'h07;
      `LBB_ADDR_PWM: return 8'h0F;
      `LBB_ADDR_EN: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : mask
  function automatic logic [7:0] obs(input logic [7:0] a);
    case (a)
      `LBB_ADDR_SINK: return {5'h00, sink_bank_b};
      `LBB_ADDR_FB: return {5'h00, sink_feedback_en};
      `LBB_ADDR_BOOST: return {5'h00, overvoltage_limit, switching_frequency};
      `LBB_ADDR_PWM: return {4'h0, pwm_zero_detect, pwm_active_high, pwm_bank_b_en,
        pwm_bank_a_en};
      `LBB_ADDR_EN: return {6'h00, bank_b_enable, bank_a_enable};
      default: return 8'h00;
    endcase
  endfunction : obs
  function automatic lbb_pkg::lbb_level_t exp_target(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo[2:0]};
  endfunction : exp_target
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic setreg(input logic [7:0] a, input logic [7:0] d);
    logic m;
    m = mask(a) != 8'h00 || a == `LBB_ADDR_LOW || a == `LBB_ADDR_HIGH;
    u_lbb_host_model.write_reg(a, d, ok);
    if (m) chk("write ack", 16'h0001, 16'(ok));
    u_lbb_host_model.read_reg(a, rd, ok);
    chk("read back", 16'(m ? d : 8'h00), 16'(rd));
    chk("field", 16'(d & mask(a)), 16'(obs(a)));
  endtask : setreg
  task automatic await_level(input lbb_pkg::lbb_level_t e, input int steps);
    int n;
    n = steps * `LBB_STEP_CYC;
    while (bank_a_level !== e && n > 0) begin
      @(posedge clk_sys);
      n--;
    end
    chk("ramped level", 16'(e), 16'(bank_a_level));
    repeat (`LBB_STEP_CYC + 1) @(posedge clk_sys);
    chk("held level", 16'(e), 16'(bank_a_level));
  endtask : await_level
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      complete_run();
    end
  end
  // Level moves one code per tick; ticks are a fixed grid
  always @(posedge clk_sys) begin
    if (!rst_n || !hardware_enable_pin) begin
      seen = 1'b0;
      gap = 0;
    end else begin
      gap++;
      if (bank_a_level !== lvl_prev) begin
        if (seen) chk("ramp spacing", 16'h0000, 16'(gap % `LBB_STEP_CYC));
        chk("ramp step", 16'h0001, 16'(lvl_prev > bank_a_level ?
          lvl_prev - bank_a_level : bank_a_level - lvl_prev));
        seen = 1'b1;
        gap = 0;
      end
    end
    lvl_prev = bank_a_level;
  end
  initial begin
    rst_n = 1'b0;
    hardware_enable_pin = 1'b1;
    void'($urandom(32'h5a26));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // 2048 us, exponential, 20200 uA
    chk("ramp time", 16'h0800, 16'(ramp_time_us));
    chk("mapping", 16'h0001, 16'(map_exponential));
    chk("full scale", 16'h4EE8, full_scale_ua);
    chk("reset target", 16'h0000, 16'(bank_a_target));
    foreach (regs[i]) begin
      chk("reset field", 16'h0000, 16'(obs(regs[i])));
      u_lbb_host_model.read_reg(regs[i], rd, ok);
      chk("reset read", 16'h0000, 16'(rd));
    end
    // Foreign slave address is not answered
    u_lbb_host_model.bus_start();
    u_lbb_host_model.put_byte({~`LBB_DEV_ADDR, 1'b0}, ok);
    u_lbb_host_model.bus_stop();
    chk("foreign ack", 16'h0000, 16'(ok));
    setreg(`LBB_ADDR_SINK, 8'h04);
    setreg(`LBB_ADDR_FB, 8'h03);
    setreg(`LBB_ADDR_BOOST, 8'h04);
    chk("limit", 16'(`LBB_LIMIT_32V), 16'(overvoltage_limit));
    setreg(`LBB_ADDR_BOOST, 8'h02);
    chk("limit", 16'(`LBB_LIMIT_24V), 16'(overvoltage_limit));
    chk("frequency", 16'h0000, 16'(switching_frequency));
    setreg(`LBB_ADDR_PWM, 8'h0D);
    setreg(`LBB_ADDR_EN, 8'h01);
    repeat (2) foreach (regs[i]) setreg(regs[i], 8'($urandom));
    setreg(8'h30, 8'($urandom));
    setreg(`LBB_ADDR_BOOST, 8'h06);
    hardware_enable_pin <= 1'b0;
    repeat (2) @(posedge clk_sys);
    hardware_enable_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (regs[i]) chk("enable reset", 16'h0000, 16'(obs(regs[i])));
    chk("level reset", 16'h0000, 16'(bank_a_level));
    // Slow host for the 8-bit mode setup
    u_lbb_host_model.half = 4;
    setreg(`LBB_ADDR_LOW, 8'h00);
    setreg(`LBB_ADDR_HIGH, 8'h01);
    u_lbb_host_model.half = 2;
    await_level(exp_target(8'h01, 8'h00), 10);
    setreg(`LBB_ADDR_LOW, 8'h05);
    chk("pending low", 16'(exp_target(8'h01, 8'h00)), 16'(bank_a_target));
    setreg(`LBB_ADDR_HIGH, 8'h01);
    chk("applied low", 16'(exp_target(8'h01, 8'h05)), 16'(bank_a_target));
    await_level(exp_target(8'h01, 8'h05), 7);
    // 11-bit mode needs PWM back on after the enable reset
    setreg(`LBB_ADDR_PWM, 8'h0D);
    u_lbb_host_model.write_level(8'h02, 8'h01, ok);
    chk("level write", 16'(exp_target(8'h01, 8'h02)), 16'(bank_a_target));
    await_level(exp_target(8'h01, 8'h02), 5);
    complete_run();
  end
endmodule : tb_top
